// *** design/sis_pkg.sv ***
package sis_pkg;

    // Timing
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned TRAVEL_MAX_MS   = 200;
    localparam int unsigned TRAVEL_CYCLES   = (CLK_HZ / 1000) * TRAVEL_MAX_MS;
    localparam int unsigned FILT_CYCLES     = 4;
    localparam int unsigned CNT_W           = 24;

    // Register offsets
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ    = 4'h2;
    localparam logic [3:0] ADDR_MASK   = 4'h3;

    // Control fields
    localparam int unsigned CTRL_FAULT_CLR = 0;
    localparam int unsigned CTRL_SW_ENABLE = 1;
    localparam logic [7:0]  CTRL_RESET     = 8'h02;

    // Event bits
    localparam int unsigned EV_SHUT_FAULT = 0;
    localparam int unsigned EV_TEMP_FAULT = 1;
    localparam int unsigned EV_LOOP_OPEN  = 2;
    localparam int unsigned EV_W          = 3;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

    typedef enum logic [3:0] {
        SH_IDLE    = 4'b0001,
        SH_OPEN    = 4'b0010,
        SH_CLOSED  = 4'b0100,
        SH_MOVING  = 4'b1000
    } sis_shut_e;

    typedef struct packed {
        logic system_loop;
        logic shutter_loop;
        logic shutter_req;
        logic sense_open;
        logic sense_closed;
        logic over_temp;
    } sis_pins_s;

    typedef struct packed {
        logic [3:0]  addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } sis_bus_s;

endpackage

// *** design/sis_sync.sv ***
`timescale 1ns/1ps
module sis_sync
(
    input  wire logic                                 clk_i,  // System clock
    input  wire logic                                 rst_i,  // Sync reset
    input  wire sis_pkg::sis_pins_s                   d_i,    // Raw pins
    output sis_pkg::sis_pins_s                        q_o     // Synchronised pins
);
    typedef struct packed {
        sis_pkg::sis_pins_s meta;
        sis_pkg::sis_pins_s sync;
    } sis_sync_s;

    sis_sync_s st;
    sis_sync_s next_st;

    always_comb
    begin
        next_st.meta = d_i;
        next_st.sync = st.meta;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign q_o = st.sync;
endmodule // sis_sync

// *** design/sis_supervisor.sv ***
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - Modulation allowed only with system loop closed
// - Open system loop stops modulation at once
// - Shutter loop closed means fitted, enables shutter
// - Shutter driven per request input level
// - Closed indication only fitted and sensed closed
// - Latching fault disables shutter, clears closed
// - Separate open and closed position outputs
// - Latch shutter fault when faulty or stuck
// - Latch thermal fault, shuts system down
// - Shutter signals meaningful only when fitted
// - Fault on travel timeout or missing closed
// - Shutter fault shuts whole system down
// - Open indication only fitted, open, no fault
// - Shutter loop never blocks system operation
module sis_supervisor
#(
    parameter int unsigned TRAVEL_CYCLES = sis_pkg::TRAVEL_CYCLES  // Travel timeout
)
(
    input  wire logic          clk_i,           // System clock 20 MHz
    input  wire logic          rst_i,           // Sync reset, active high
    input  wire logic          system_loop_i,   // System interlock closed
    input  wire logic          shutter_loop_i,  // Shutter interlock closed
    input  wire logic          shutter_req_i,   // High requests shutter open
    input  wire logic          sense_open_i,    // Shutter open sensor
    input  wire logic          sense_closed_i,  // Shutter closed sensor
    input  wire logic          over_temp_i,     // Temperature out of range
    input  wire logic          mod_i,           // Modulation request
    input  wire logic [3:0]    addr_i,          // Register address
    input  wire logic [7:0]    wdata_i,         // Write data
    input  wire logic          wr_i,            // Write strobe
    input  wire logic          rd_i,            // Read strobe
    output logic [7:0]         rdata_o,         // Read data, cycle after read
    output logic               mod_o,           // Gated modulation
    output logic               system_ok_o,     // System not shut down
    output logic               shutter_en_o,    // Shutter drive enabled
    output logic               shutter_drive_o, // Drive toward open
    output logic               shut_open_o,     // Shutter open status
    output logic               shut_closed_o,   // Shutter closed status
    output logic               shut_fault_o,    // Shutter latching fault
    output logic               temp_fault_o,    // Over temperature latching fault
    output logic               irq_o            // Interrupt, level
);
    localparam int unsigned W = sis_pkg::CNT_W;
    localparam logic [W-1:0] TRAVEL_LIM = W'(TRAVEL_CYCLES);
    localparam logic [W-1:0] FILT_LIM   = W'(sis_pkg::FILT_CYCLES);

    typedef struct packed {
        sis_pkg::sis_shut_e          shut;
        logic [W-1:0]                cnt;
        logic [W-1:0]                cmis;
        logic                        shut_fault;
        logic                        temp_fault;
        logic [7:0]                  ctrl;
        logic [sis_pkg::EV_W-1:0]    irq_stat;
        logic [sis_pkg::EV_W-1:0]    irq_mask;
        logic [7:0]                  rdata;
        logic                        mod;
        logic                        en;
        logic                        drive;
        logic                        open_st;
        logic                        closed_st;
        logic                        loop_q;
    } sis_state_s;

    sis_pkg::sis_pins_s raw;
    sis_pkg::sis_pins_s pin;
    sis_state_s         st;
    sis_state_s         next_st;

    assign raw = '{system_loop:  system_loop_i,
                   shutter_loop: shutter_loop_i,
                   shutter_req:  shutter_req_i,
                   sense_open:   sense_open_i,
                   sense_closed: sense_closed_i,
                   over_temp:    over_temp_i};

    sis_sync u_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (raw),
        .q_o   (pin)
    );

    function automatic logic [W-1:0] sat_inc(input logic [W-1:0] v, input logic [W-1:0] lim);
        sat_inc = (v >= lim) ? lim : W'(v + W'(1));
    endfunction

    logic fault_any;
    logic fitted;
    logic wr_ctrl;
    logic [sis_pkg::EV_W-1:0] ev;

    always_comb
    begin
        next_st   = st;
        fitted    = pin.shutter_loop;
        fault_any = st.shut_fault | st.temp_fault;
        wr_ctrl   = wr_i && (addr_i == sis_pkg::ADDR_CTRL);
        ev        = '0;

        // Shutter position tracking and travel supervision
        if (!fitted || fault_any)
        begin
            next_st.shut = sis_pkg::SH_IDLE;
            next_st.cnt  = '0;
            next_st.cmis = '0;
        end
        else
        begin
            case (st.shut)
                sis_pkg::SH_IDLE:
                    next_st.shut = sis_pkg::SH_MOVING;
                sis_pkg::SH_MOVING:
                begin
                    next_st.cnt = sat_inc(st.cnt, TRAVEL_LIM);
                    if (pin.shutter_req && pin.sense_open && !pin.sense_closed)
                        next_st.shut = sis_pkg::SH_OPEN;
                    else if (!pin.shutter_req && pin.sense_closed && !pin.sense_open)
                        next_st.shut = sis_pkg::SH_CLOSED;
                    else if (st.cnt >= TRAVEL_LIM - W'(1))
                        next_st.shut_fault = 1'b1;
                end
                sis_pkg::SH_OPEN:
                    if (!pin.shutter_req || !pin.sense_open)
                    begin
                        next_st.shut = sis_pkg::SH_MOVING;
                        next_st.cnt  = '0;
                    end
                sis_pkg::SH_CLOSED:
                    if (pin.shutter_req || !pin.sense_closed)
                    begin
                        next_st.shut = sis_pkg::SH_MOVING;
                        next_st.cnt  = '0;
                    end
                default:
                    next_st.shut = sis_pkg::SH_IDLE;
            endcase
            // Close requested but closed sensor lost while settled
            if (st.shut == sis_pkg::SH_CLOSED && !pin.sense_closed)
            begin
                next_st.cmis = sat_inc(st.cmis, FILT_LIM);
                if (st.cmis >= FILT_LIM - W'(1))
                    next_st.shut_fault = 1'b1;
            end
            else
                next_st.cmis = '0;
        end

        if (pin.over_temp)
            next_st.temp_fault = 1'b1;

        // Faults cleared only by reset or explicit clear with cause gone
        if (wr_ctrl && wdata_i[sis_pkg::CTRL_FAULT_CLR])
        begin
            if (!pin.over_temp)
                next_st.temp_fault = 1'b0;
            // A fault raised in this same cycle is kept: set wins
            if (st.shut != sis_pkg::SH_MOVING && st.shut_fault)
                next_st.shut_fault = 1'b0;
        end

        // Outputs registered
        next_st.mod       = mod_i && pin.system_loop && !fault_any
                            && st.ctrl[sis_pkg::CTRL_SW_ENABLE];
        next_st.en        = fitted && !fault_any;
        next_st.drive     = fitted && !fault_any && pin.shutter_req;
        next_st.open_st   = fitted && !fault_any && pin.sense_open
                            && !pin.sense_closed;
        next_st.closed_st = fitted && !fault_any && pin.sense_closed
                            && !pin.sense_open;
        next_st.loop_q    = pin.system_loop;

        // Interrupt events: set wins over clear
        ev[sis_pkg::EV_SHUT_FAULT] = next_st.shut_fault & ~st.shut_fault;
        ev[sis_pkg::EV_TEMP_FAULT] = next_st.temp_fault & ~st.temp_fault;
        ev[sis_pkg::EV_LOOP_OPEN]  = st.loop_q & ~pin.system_loop;
        if (wr_i && addr_i == sis_pkg::ADDR_IRQ)
            next_st.irq_stat = st.irq_stat & ~wdata_i[sis_pkg::EV_W-1:0];
        next_st.irq_stat = next_st.irq_stat | ev;

        if (wr_ctrl)
            next_st.ctrl = wdata_i & ~(8'h01 << sis_pkg::CTRL_FAULT_CLR);
        if (wr_i && addr_i == sis_pkg::ADDR_MASK)
            next_st.irq_mask = wdata_i[sis_pkg::EV_W-1:0];

        next_st.rdata = '0;
        if (rd_i)
        begin
            case (addr_i)
                sis_pkg::ADDR_CTRL:   next_st.rdata = st.ctrl;
                sis_pkg::ADDR_STATUS: next_st.rdata = {st.shut, st.temp_fault,
                                                       st.shut_fault, fitted,
                                                       pin.system_loop};
                sis_pkg::ADDR_IRQ:    next_st.rdata = {5'h00, st.irq_stat};
                sis_pkg::ADDR_MASK:   next_st.rdata = {5'h00, st.irq_mask};
                default:              next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st          <= '0;
            st.shut     <= sis_pkg::SH_IDLE;
            st.ctrl     <= sis_pkg::CTRL_RESET;
            st.irq_mask <= sis_pkg::MASK_RESET;
        end
        else
            st <= next_st;
    end

    assign rdata_o         = st.rdata;
    assign mod_o           = st.mod;
    assign system_ok_o     = !(st.shut_fault | st.temp_fault);
    assign shutter_en_o    = st.en;
    assign shutter_drive_o = st.drive;
    assign shut_open_o     = st.open_st;
    assign shut_closed_o   = st.closed_st;
    assign shut_fault_o    = st.shut_fault;
    assign temp_fault_o    = st.temp_fault;
    assign irq_o           = |(st.irq_stat & st.irq_mask);

    property p_mod_loop;
        @(posedge clk_i) disable iff (rst_i)
        mod_o |-> $past(pin.system_loop);
    endproperty
    a_mod_loop: assert property (p_mod_loop) else $error("modulation without loop");

    property p_loop_open;
        @(posedge clk_i) disable iff (rst_i)
        !pin.system_loop |=> !mod_o;
    endproperty
    a_loop_open: assert property (p_loop_open) else $error("loop open, mod on");

    property p_en_fit;
        @(posedge clk_i) disable iff (rst_i)
        shutter_en_o |-> $past(pin.shutter_loop);
    endproperty
    a_en_fit: assert property (p_en_fit) else $error("shutter enabled unfitted");

    property p_drive;
        @(posedge clk_i) disable iff (rst_i)
        $past(pin.shutter_loop && !fault_any) |-> shutter_drive_o == $past(pin.shutter_req);
    endproperty
    a_drive: assert property (p_drive) else $error("drive not following request");

    property p_closed;
        @(posedge clk_i) disable iff (rst_i)
        shut_closed_o |-> $past(pin.shutter_loop && pin.sense_closed);
    endproperty
    a_closed: assert property (p_closed) else $error("closed without sense");

    property p_fault_off;
        @(posedge clk_i) disable iff (rst_i)
        (shut_fault_o || temp_fault_o) ##1 (shut_fault_o || temp_fault_o)
        |-> !shut_closed_o && !shut_open_o && !shutter_en_o;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault, shutter active");

    property p_excl;
        @(posedge clk_i) disable iff (rst_i)
        !(shut_open_o && shut_closed_o);
    endproperty
    a_excl: assert property (p_excl) else $error("open and closed both set");

    property p_temp;
        @(posedge clk_i) disable iff (rst_i)
        pin.over_temp |=> temp_fault_o ##1 !mod_o;
    endproperty
    a_temp: assert property (p_temp) else $error("thermal fault missed");

    property p_latch;
        @(posedge clk_i) disable iff (rst_i)
        shut_fault_o && !(wr_ctrl && wdata_i[sis_pkg::CTRL_FAULT_CLR]) |=> shut_fault_o;
    endproperty
    a_latch: assert property (p_latch) else $error("shutter fault dropped");

    sequence s_stuck;
        (st.shut == sis_pkg::SH_MOVING) && (st.cnt >= TRAVEL_LIM - W'(1)) && fitted
        && !fault_any;
    endsequence
    property p_timeout;
        @(posedge clk_i) disable iff (rst_i)
        (s_stuck and !(pin.sense_open ^ pin.sense_closed)) |=> shut_fault_o;
    endproperty
    a_timeout: assert property (p_timeout) else $error("travel timeout missed");
endmodule // sis_supervisor

// *** testbench/sis_shutter_model.sv ***
`timescale 1ns/1ps
module sis_shutter_model
#(
    parameter int unsigned TRAVEL_DLY = 10  // One swing takes this many cycles plus one
)
(
    input  wire logic clk_i,           // System clock
    input  wire logic enable_i,        // Shutter drive powered
    input  wire logic drive_i,         // High drives toward open
    input  wire logic stuck_i,         // Jams the blade partway
    output logic      sense_open_o,    // Blade at open stop
    output logic      sense_closed_o   // Blade at closed stop
);
    logic       pos_open = 1'b0;
    logic [7:0] cnt      = 8'h00;
    logic       in_travel;

    // Powered and not yet at the commanded stop: neither sensor shows
    assign in_travel      = enable_i && (pos_open != drive_i);
    assign sense_open_o   = pos_open && !in_travel;
    assign sense_closed_o = !pos_open && !in_travel;

    always @(posedge clk_i)
    begin
        if (!in_travel)
            cnt <= 8'h00;
        else if (stuck_i)
            cnt <= cnt;
        else if (cnt == 8'(TRAVEL_DLY))
        begin
            pos_open <= drive_i;
            cnt      <= 8'h00;
        end
        else
            cnt <= cnt + 8'h01;
    end
endmodule // sis_shutter_model

// *** testbench/shutter_interlock_supervisor_test.sv ***
`timescale 1ns/1ps
module shutter_interlock_supervisor_test;
    logic       clk_i = 1'b0, rst_i = 1'b1, mod_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic       system_loop_i = 1'b0, shutter_loop_i = 1'b0, shutter_req_i = 1'b0;
    logic       over_temp_i = 1'b0, stuck = 1'b0, sense_open_i, sense_closed_i;
    logic [3:0] addr_i  = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, rd_val;
    logic       mod_o, system_ok_o, shutter_en_o, shutter_drive_o, irq_o;
    logic       shut_open_o, shut_closed_o, shut_fault_o, temp_fault_o, l, m, e;
    int         bad_count = 0, n_compared = 0;

    sis_supervisor #(.TRAVEL_CYCLES(50)) DUT (.clk_i, .rst_i, .system_loop_i,
        .shutter_loop_i, .shutter_req_i, .sense_open_i, .sense_closed_i, .over_temp_i,
        .mod_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .mod_o, .system_ok_o,
        .shutter_en_o, .shutter_drive_o, .shut_open_o, .shut_closed_o, .shut_fault_o,
        .temp_fault_o, .irq_o);

    sis_shutter_model u_shutter (.clk_i, .enable_i(shutter_en_o),
        .drive_i(shutter_drive_o), .stuck_i(stuck), .sense_open_o(sense_open_i),
        .sense_closed_o(sense_closed_i));

    always #25 clk_i = ~clk_i;

    task give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task rd_reg(input logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        rd_val = rdata_o;
    endtask

    function automatic logic pick(input int k);
        return (k == 0) ? shut_open_o : (k == 1) ? shut_closed_o : shut_fault_o;
    endfunction

    function automatic logic exp_mod(input logic lp, input logic md, input logic en);
        return lp & md & en;
    endfunction

    task wait_for(input int k);
        for (int i = 0; i < 300 && pick(k) !== 1'b1; i++)
            settle(1);
        if (pick(k) !== 1'b1)
        begin
            bad_count++;
            $display("[ERR] t=%0t got %h expected %h", $time, pick(k), 1'b1);
            give_verdict();
        end
    endtask

    initial
    begin
        void'($urandom(32'h8a56d3cd));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(1);
        chk(mod_o, 8'h00);
        chk(system_ok_o, 8'h01);
        rd_reg(sis_pkg::ADDR_CTRL);
        chk(rd_val, sis_pkg::CTRL_RESET);
        rd_reg(sis_pkg::ADDR_MASK);
        chk(rd_val, 8'(sis_pkg::MASK_RESET));
        rd_reg(4'hF);
        chk(rd_val, 8'h00);
        $display("Test reset done");

        @(posedge clk_i);
        system_loop_i <= 1'b1;
        mod_i         <= 1'b1;
        wr_reg(sis_pkg::ADDR_MASK, 8'h04);
        settle(5);
        chk(mod_o, 8'h01);
        @(posedge clk_i);
        system_loop_i <= 1'b0;
        settle(4);
        chk(mod_o, 8'h00);
        chk(irq_o, 8'h01);
        rd_reg(sis_pkg::ADDR_IRQ);
        chk(rd_val, 8'h04);
        wr_reg(sis_pkg::ADDR_IRQ, 8'h04);
        settle(1);
        chk(irq_o, 8'h00);
        $display("Test interlock done");

        @(posedge clk_i);
        system_loop_i  <= 1'b1;
        shutter_loop_i <= 1'b1;
        shutter_req_i  <= 1'b1;
        wait_for(0);
        chk({shut_closed_o, shutter_en_o, shutter_drive_o}, 8'h03);
        @(posedge clk_i);
        shutter_req_i  <= 1'b0;
        wait_for(1);
        chk({shut_open_o, shutter_en_o, shutter_drive_o}, 8'h02);
        @(posedge clk_i);
        shutter_loop_i <= 1'b0;
        settle(5);
        chk({shutter_en_o, shut_closed_o, shut_open_o}, 8'h00);
        chk(mod_o, 8'h01);
        $display("Test shutter done");

        @(posedge clk_i);
        shutter_loop_i <= 1'b1;
        shutter_req_i  <= 1'b1;
        wait_for(0);
        @(posedge clk_i);
        stuck          <= 1'b1;
        shutter_req_i  <= 1'b0;
        wait_for(2);
        settle(2);
        chk({shut_closed_o, shut_open_o, shutter_en_o}, 8'h00);
        chk({mod_o, system_ok_o}, 8'h00);
        @(posedge clk_i);
        stuck <= 1'b0;
        settle(10);
        chk(shut_fault_o, 8'h01);
        @(posedge clk_i);
        shutter_loop_i <= 1'b0;
        settle(5);
        wr_reg(sis_pkg::ADDR_CTRL, 8'h03);
        settle(2);
        chk({shut_fault_o, system_ok_o}, 8'h01);
        rd_reg(sis_pkg::ADDR_IRQ);
        chk(rd_val, 8'h01);
        wr_reg(sis_pkg::ADDR_IRQ, 8'h01);
        $display("Test shutter fault done");

        over_temp_i <= 1'b1;
        settle(5);
        chk({temp_fault_o, system_ok_o, mod_o}, 8'h04);
        rd_reg(sis_pkg::ADDR_STATUS);
        chk(rd_val, 8'h19);
        wr_reg(sis_pkg::ADDR_CTRL, 8'h03);
        over_temp_i <= 1'b0;
        settle(6);
        chk(temp_fault_o, 8'h01);
        wr_reg(sis_pkg::ADDR_CTRL, 8'h03);
        settle(2);
        chk(temp_fault_o, 8'h00);
        $display("Test thermal fault done");

        for (int i = 0; i < 40; i++)
        begin
            l = ($urandom % 4) != 0;
            m = $urandom % 2;
            e = $urandom % 2;
            wr_reg(sis_pkg::ADDR_CTRL, {6'h00, e, 1'b0});
            system_loop_i <= l;
            mod_i         <= m;
            settle(5);
            chk(mod_o, exp_mod(l, m, e));
        end
        $display("Test random gating done");
        give_verdict();
    end
endmodule // shutter_interlock_supervisor_test
